// *** design/spc_pkg.sv ***
// Package: register map, field layout and encodings of the serial port block
package spc_pkg;
	localparam logic [7:0]  CTRL_OFS    = 8'h00;
	localparam logic [7:0]  DATA_OFS    = 8'h04;
	localparam logic [7:0]  STAT_OFS    = 8'h08;
	localparam logic [7:0]  BAUD_OFS    = 8'h0c;
	localparam logic [15:0] CTRL_RESET  = 16'h0000;
	localparam logic [15:0] CTRL_WMASK  = 16'h87ff;
	localparam logic [7:0]  BAUD_RESET  = 8'h04;
	localparam logic [3:0]  LAST_EDGE   = 4'hf;
	localparam logic [1:0]  LEAD_LAST   = 2'h1;
	localparam logic [1:0]  DEPTH_STD   = 2'h1;
	localparam logic [1:0]  DEPTH_ENH   = 2'h2;
	localparam int          SYNC_W      = 4;
	localparam logic [3:0]  SYNC_INIT   = 4'h4;
	localparam int          ST_BUSY     = 0;
	localparam int          ST_TXFULL   = 1;
	localparam int          ST_RXFULL   = 2;
	localparam int          ST_RXOVF    = 3;
	localparam int          ST_TXOVF    = 4;

	typedef struct packed {
		logic       moduleOn;
		logic [3:0] reserved;
		logic       framedModeOn;
		logic       audioModeOn;
		logic       transmitEdge;
		logic       slaveSelectUse;
		logic       clockIdlePolarity;
		logic       masterRoleSelect;
		logic       serialInRelease;
		logic       serialClockRelease;
		logic       baudSourceSelect;
		logic       framePulseEdge;
		logic       enhancedBufferOn;
	} spc_ctrl_t;

	typedef struct packed {
		logic mclk;
		logic ss;
		logic sdi;
		logic sck;
	} spc_pins_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LEAD  = 2'b01,
		ST_SHIFT = 2'b11
	} spc_state_t;
endpackage : spc_pkg

// *** design/spc_sync.sv ***
// Three-stage input synchroniser; output moves when stages two and three agree
`timescale 1ns/1ns
module spc_sync #(
	parameter int           W    = 4,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] async,
	output logic      [W-1:0] sync
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					stage1[i] <= INIT[i];
					stage2[i] <= INIT[i];
					stage3[i] <= INIT[i];
					sync[i]   <= INIT[i];
				end else begin
					stage1[i] <= async[i];
					stage2[i] <= stage1[i];
					stage3[i] <= stage2[i];
					if (stage2[i] == stage3[i]) begin
						sync[i] <= stage3[i];
					end
				end
			end
		end
	endgenerate
endmodule : spc_sync

// *** design/spc_serial_port.sv ***
// Serial port engine with its low control register, reached over APB
`timescale 1ns/1ns
module spc_serial_port (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sckIn,
	output logic             sckOut,
	output logic             sckOeN,
	input  wire logic        sdiIn,
	output logic             sdoOut,
	output logic             sdoOeN,
	input  wire logic        slaveSelectN,
	input  wire logic        mclkIn,
	output logic             frameOut,
	output logic             sdiOwned,
	output logic             sckOwned,
	output logic             ssOwned
);
	spc_pkg::spc_ctrl_t  ctrl;
	spc_pkg::spc_ctrl_t  next_ctrl;
	spc_pkg::spc_state_t state;
	spc_pkg::spc_state_t next_state;
	spc_pkg::spc_pins_t  pinsRaw;
	spc_pkg::spc_pins_t  pinsSync;
	logic [7:0]  baudDiv;
	logic [7:0]  brgCnt;
	logic [7:0]  txShift;
	logic [7:0]  rxShift;
	logic [7:0]  rxData;
	logic [7:0]  txq [0:1];
	logic [1:0]  txCount;
	logic [1:0]  leadCnt;
	logic [3:0]  edgeCnt;
	logic [15:0] statusWord;
	logic        sckLevel;
	logic        sckPrev;
	logic        mclkPrev;
	logic        rxFull;
	logic        rxOvf;
	logic        txOvf;

	function automatic logic isReg(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : isReg

	assign pinsRaw = '{mclk: mclkIn, ss: slaveSelectN, sdi: sdiIn, sck: sckIn};

	spc_sync #(
		.W    (spc_pkg::SYNC_W),
		.INIT (spc_pkg::SYNC_INIT)
	) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.async  (pinsRaw),
		.sync   (pinsSync)
	);

	// Bus decode
	wire logic setup   = psel & ~penable;
	wire logic access  = psel & penable;
	wire logic selCtrl = isReg(paddr, spc_pkg::CTRL_OFS);
	wire logic selData = isReg(paddr, spc_pkg::DATA_OFS);
	wire logic selStat = isReg(paddr, spc_pkg::STAT_OFS);
	wire logic selBaud = isReg(paddr, spc_pkg::BAUD_OFS);
	wire logic hit     = selCtrl | selData | selStat | selBaud;
	wire logic ctrlWr  = access & pwrite & selCtrl;
	wire logic dataWr  = access & pwrite & selData;
	wire logic dataRd  = access & ~pwrite & selData;
	wire logic statWr  = access & pwrite & selStat;
	wire logic baudWr  = access & pwrite & selBaud;

	assign pready  = 1'b1;
	assign pslverr = access & ~hit;

	// Effective modes
	wire logic ckeEff   = ctrl.transmitEdge & ~ctrl.audioModeOn;
	wire logic isMaster = ctrl.moduleOn & ctrl.masterRoleSelect;
	wire logic isSlave  = ctrl.moduleOn & ~ctrl.masterRoleSelect;
	wire logic ssUse    = isSlave & ctrl.slaveSelectUse & ~ctrl.framedModeOn;
	wire logic selected = ~ssUse | ~pinsSync.ss;
	wire logic sdiEff   = ~ctrl.serialInRelease & pinsSync.sdi;
	wire logic sckSeen  = ~ctrl.serialClockRelease & pinsSync.sck;
	wire logic clock_idle_polarity      = ctrl.clockIdlePolarity;

	assign ssOwned  = ssUse;
	assign sdiOwned = ctrl.moduleOn & ~ctrl.serialInRelease;
	assign sckOwned = ctrl.moduleOn & ~ctrl.serialClockRelease;
	assign sckOeN   = ~(isMaster & ~ctrl.serialClockRelease);
	assign sdoOeN   = ~(ctrl.moduleOn & selected);
	assign sckOut   = sckLevel;

	// Baud generator
	wire logic srcTick = ctrl.baudSourceSelect ? (pinsSync.mclk & ~mclkPrev) : 1'b1;
	wire logic brgTick = isMaster & (state != spc_pkg::ST_IDLE) & srcTick & (brgCnt == baudDiv);

	// Clock edges, master from the generator, slave from the pin
	wire logic atIdle   = sckLevel == clock_idle_polarity;
	wire logic mLead    = brgTick & (state == spc_pkg::ST_SHIFT) & atIdle;
	wire logic mTrail   = brgTick & (state == spc_pkg::ST_SHIFT) & ~atIdle;
	wire logic sckChg   = isSlave & selected & (sckSeen != sckPrev);
	wire logic sLead    = sckChg & (sckSeen != clock_idle_polarity);
	wire logic sTrail   = sckChg & (sckSeen == clock_idle_polarity);
	wire logic leadEv   = mLead | sLead;
	wire logic trailEv  = mTrail | sTrail;
	wire logic anyEv    = leadEv | trailEv;
	wire logic shiftEv  = ckeEff ? trailEv : leadEv;
	wire logic sampleEv = ckeEff ? leadEv : trailEv;
	wire logic lastEdge = anyEv & (edgeCnt == spc_pkg::LAST_EDGE);
	wire logic [7:0] rxNext = {rxShift[6:0], sdiEff};
	wire logic firstBit = (edgeCnt == 4'h0) | ((edgeCnt == 4'h1) & ~trailEv);

	// Transmit buffer
	wire logic [1:0] txCap = ctrl.enhancedBufferOn ? spc_pkg::DEPTH_ENH : spc_pkg::DEPTH_STD;
	wire logic room    = txCount < txCap;
	wire logic push    = dataWr & room;
	wire logic pop     = lastEdge & (txCount != 2'h0);
	wire logic pushIdx = pop ? 1'b0 : txCount[0];
	wire logic [7:0] head = (txCount != 2'h0) ? txq[0] : 8'h00;
	wire logic startM  = isMaster & (state == spc_pkg::ST_IDLE) & (txCount != 2'h0);
	wire logic abort   = ~ctrl.moduleOn | (isSlave & ~selected);

	always_comb begin
		next_ctrl = spc_pkg::spc_ctrl_t'(pwdata[15:0] & spc_pkg::CTRL_WMASK);
		if (ctrl.moduleOn) begin
			next_ctrl.baudSourceSelect = ctrl.baudSourceSelect;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			spc_pkg::ST_IDLE: begin
				if (startM) begin
					next_state = (ctrl.framedModeOn & ~ctrl.framePulseEdge) ? spc_pkg::ST_LEAD
						: spc_pkg::ST_SHIFT;
				end else if (sLead | sTrail) begin
					next_state = spc_pkg::ST_SHIFT;
				end
			end
			spc_pkg::ST_LEAD: begin
				if (brgTick & (leadCnt == spc_pkg::LEAD_LAST)) begin
					next_state = spc_pkg::ST_SHIFT;
				end
			end
			spc_pkg::ST_SHIFT: begin
				if (lastEdge) begin
					next_state = spc_pkg::ST_IDLE;
				end
			end
			default: next_state = spc_pkg::ST_IDLE;
		endcase
		if (abort) begin
			next_state = spc_pkg::ST_IDLE;
		end
	end

	always_comb begin
		statusWord = '0;
		statusWord[spc_pkg::ST_BUSY]   = state != spc_pkg::ST_IDLE;
		statusWord[spc_pkg::ST_TXFULL] = ~room;
		statusWord[spc_pkg::ST_RXFULL] = rxFull;
		statusWord[spc_pkg::ST_RXOVF]  = rxOvf;
		statusWord[spc_pkg::ST_TXOVF]  = txOvf;
	end

	wire logic [31:0] readWord = selCtrl ? {16'h0000, ctrl}
		: selData ? {24'h000000, rxData}
		: selStat ? {16'h0000, statusWord}
		: selBaud ? {24'h000000, baudDiv} : 32'h00000000;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl    <= spc_pkg::spc_ctrl_t'(spc_pkg::CTRL_RESET);
			baudDiv <= spc_pkg::BAUD_RESET;
			prdata  <= 32'h00000000;
		end else begin
			if (ctrlWr) begin
				ctrl <= next_ctrl;
			end
			if (baudWr) begin
				baudDiv <= pwdata[7:0];
			end
			if (setup) begin
				prdata <= readWord;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state    <= spc_pkg::ST_IDLE;
			brgCnt   <= 8'h00;
			leadCnt  <= 2'h0;
			sckLevel <= 1'b0;
			sckPrev  <= 1'b0;
			mclkPrev <= 1'b0;
			frameOut <= 1'b0;
		end else begin
			state    <= next_state;
			sckPrev  <= sckSeen;
			mclkPrev <= pinsSync.mclk;
			brgCnt   <= (~isMaster | (state == spc_pkg::ST_IDLE) | brgTick) ? 8'h00
				: (srcTick ? brgCnt + 8'h01 : brgCnt);
			leadCnt  <= (state != spc_pkg::ST_LEAD) ? 2'h0 : (brgTick ? leadCnt + 2'h1 : leadCnt);
			sckLevel <= (state != spc_pkg::ST_SHIFT) ? clock_idle_polarity : (brgTick ? ~sckLevel : sckLevel);
			frameOut <= isMaster & ctrl.framedModeOn & ((next_state == spc_pkg::ST_LEAD)
				| ((next_state == spc_pkg::ST_SHIFT) & ctrl.framePulseEdge & firstBit));
		end
	end

	// Shift engine
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			edgeCnt <= 4'h0;
			txShift <= 8'h00;
			rxShift <= 8'h00;
			sdoOut  <= 1'b0;
		end else if (abort | ((state == spc_pkg::ST_IDLE) & ~anyEv)) begin
			edgeCnt <= 4'h0;
			txShift <= head;
			sdoOut  <= head[7];
		end else if (anyEv) begin
			edgeCnt <= edgeCnt + 4'h1;
			if (sampleEv) begin
				rxShift <= rxNext;
			end
			if (shiftEv) begin
				sdoOut  <= ckeEff ? txShift[6] : txShift[7];
				txShift <= {txShift[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			txCount <= 2'h0;
			txq[0]  <= 8'h00;
			txq[1]  <= 8'h00;
			rxData  <= 8'h00;
			rxFull  <= 1'b0;
			rxOvf   <= 1'b0;
			txOvf   <= 1'b0;
		end else begin
			txCount <= txCount + {1'b0, push} - {1'b0, pop};
			if (pop) begin
				txq[0] <= txq[1];
			end
			if (push) begin
				txq[pushIdx] <= pwdata[7:0];
			end
			if (lastEdge) begin
				rxData <= sampleEv ? rxNext : rxShift;
			end
			rxFull <= lastEdge | (rxFull & ~dataRd);
			rxOvf  <= (lastEdge & rxFull & ~dataRd) | (rxOvf & ~(statWr & pwdata[spc_pkg::ST_RXOVF]));
			txOvf  <= (dataWr & ~room) | (txOvf & ~(statWr & pwdata[spc_pkg::ST_TXOVF]));
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_idle_level: assert property ((state != spc_pkg::ST_SHIFT) |=> sckOut == $past(clock_idle_polarity))
		else $error("serial clock not at idle level outside a transfer");
	a_baud_lock: assert property ((ctrlWr && ctrl.moduleOn) |=> $stable(ctrl.baudSourceSelect))
		else $error("baud source changed while module on");
	a_slave_clock: assert property ((isSlave && $stable(clock_idle_polarity))[*2] |-> $stable(sckOut))
		else $error("slave toggled its own serial clock");
	a_sdi_release: assert property ((ctrl.serialInRelease && sampleEv) |=> rxShift[0] == 1'b0)
		else $error("released data input still sampled");
	a_sck_release: assert property ((isSlave && ctrl.serialClockRelease)[*2] |-> !anyEv)
		else $error("released clock pin still used");
	a_select_hold: assert property ((ssUse && pinsSync.ss && state == spc_pkg::ST_IDLE) |=> state == spc_pkg::ST_IDLE)
		else $error("transfer began while deselected");
	a_framed_no_ss: assert property ((isSlave && ctrl.framedModeOn && state == spc_pkg::ST_SHIFT && !lastEdge)
		|=> state == spc_pkg::ST_SHIFT)
		else $error("framed slave aborted by select pin");
	a_frame_lead: assert property ((startM && ctrl.framedModeOn && !ctrl.framePulseEdge)
		|=> frameOut && state == spc_pkg::ST_LEAD ##1 sckOut == $past(clock_idle_polarity))
		else $error("frame pulse does not lead first clock");
	a_frame_first: assert property ((startM && ctrl.framedModeOn && ctrl.framePulseEdge)
		|=> frameOut && state == spc_pkg::ST_SHIFT)
		else $error("frame pulse not with first clock");
	a_brg_rate: assert property ((mLead || mTrail) && !ctrl.baudSourceSelect |=> sckOut != $past(sckOut))
		else $error("generator tick did not move the clock");
	a_std_depth: assert property ((dataWr && !ctrl.enhancedBufferOn && txCount != 2'h0) |=> txOvf)
		else $error("standard buffer accepted a second word");
	a_edge_select: assert property ((shiftEv && !lastEdge && ckeEff) |=> sdoOut == $past(txShift[6]))
		else $error("data not shifted on trailing edge");
	a_audio_edge: assert property ((ctrl.audioModeOn && leadEv) |=> sdoOut == $past(txShift[7]))
		else $error("audio mode ignored forced edge");
endmodule : spc_serial_port

// *** testbench/spc_link_partner.sv ***
// Far-side serial device: shifts a byte in and out on the clock that the port drives
`timescale 1ns/1ns
module spc_link_partner (
	input  wire logic       sck,
	input  wire logic       sdo,
	input  wire logic       idlePol,
	input  wire logic       sampleLeading,
	input  wire logic       load,
	input  wire logic [7:0] txByte,
	output logic            sdi,
	output logic      [7:0] rxByte
);
	logic [7:0] sh;
	logic       first;

	initial begin
		sdi = 1'b1;
		rxByte = 8'h00;
		sh = 8'h00;
		first = 1'b0;
	end

	always @(posedge load) begin
		sh = txByte;
		sdi = txByte[7];
		rxByte = 8'h00;
		first = 1'b1;
	end

	// A clock leaving its idle level is a leading edge
	always @(sck) begin : edgeSeen
		logic lead;
		lead = (sck !== idlePol);
		if (lead == sampleLeading) begin
			rxByte = {rxByte[6:0], sdo};
		end else begin
			// Bit 7 already stands on the line before a leading drive edge
			if (!(first && !sampleLeading)) begin
				sh = {sh[6:0], ~sh[0]};
			end
			first = 1'b0;
			sdi = sh[7];
		end
	end
endmodule : spc_link_partner

// *** testbench/tb.sv ***
// Self-checking testbench of the serial port block
`timescale 1ns/1ns
module tb;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdv;
	logic        pready, pslverr, err, sckOut, sckOeN, sdi, sdoOut, sdoOeN;
	logic        frameOut, sdiOwned, sckOwned, ssOwned;
	logic        mclkIn = 1'b0, mclkRun = 1'b0, load = 1'b0, sampLead = 1'b0, idlePol = 1'b0;
	logic [2:0]  mclkDiv = 3'h0;
	logic [7:0]  txByte = 8'h00, rxByte;
	int          fails = 0, total_checks = 0;
	logic [15:0] rowCtrl [7] = '{16'h8020, 16'h8028, 16'h8010, 16'h8080, 16'h8480, 16'h80a0, 16'h8040};
	// Expected {sdiOwned, sckOwned, ssOwned, sckOeN, sckOut}
	logic [4:0]  rowExp [7] = '{5'b11000, 5'b10010, 5'b01010, 5'b11110, 5'b11010, 5'b11000, 5'b11011};

	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (mclkRun) mclkDiv <= mclkDiv + 3'h1;
		mclkIn <= mclkDiv[2];
	end

	spc_serial_port u_dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sckIn(1'b0), .sckOut(sckOut), .sckOeN(sckOeN), .sdiIn(sdi), .sdoOut(sdoOut), .sdoOeN(sdoOeN),
		.slaveSelectN(1'b1), .mclkIn(mclkIn), .frameOut(frameOut), .sdiOwned(sdiOwned),
		.sckOwned(sckOwned), .ssOwned(ssOwned));

	spc_link_partner u_partner (.sck(sckOut), .sdo(sdoOut), .idlePol(idlePol), .sampleLeading(sampLead),
		.load(load), .txByte(txByte), .sdi(sdi), .rxByte(rxByte));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		forever begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		chk(name, rdv, exp);
	endtask : rdc

	task automatic xfer(input logic [15:0] ctrl, input logic lead, input logic useMclk, input logic [7:0] tx,
			input logic [7:0] pb);
		int n;
		apb(1'b1, spc_pkg::CTRL_OFS, {16'h0, ctrl & 16'h7fff});
		apb(1'b1, spc_pkg::CTRL_OFS, {16'h0, ctrl});
		sampLead <= lead;
		idlePol <= ctrl[6];
		txByte <= pb;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		apb(1'b1, spc_pkg::DATA_OFS, {24'h0, tx});
		if (useMclk) begin
			repeat (300) @(posedge clk);
			chk("clock idle without reference", {31'h0, sckOut}, {31'h0, ctrl[6]});
			mclkRun <= 1'b1;
		end
		repeat (4) @(posedge clk);
		n = 0;
		do begin
			apb(1'b0, spc_pkg::STAT_OFS, 32'h0);
			n++;
		end while (rdv[spc_pkg::ST_BUSY] !== 1'b0 && n < 3000);
		chk("partner rx", {24'h0, rxByte}, {24'h0, tx});
		rdc(spc_pkg::DATA_OFS, {24'h0, pb}, "data rx");
		mclkRun <= 1'b0;
	endtask : xfer

	task automatic conclude;
		$display("Checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	initial begin
		#500000;
		fails++;
		conclude();
	end

	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		rdc(spc_pkg::CTRL_OFS, 32'h0, "ctrl reset");
		rdc(spc_pkg::BAUD_OFS, {24'h0, spc_pkg::BAUD_RESET}, "baud reset");
		chk("clock enable after reset", {31'h0, sckOeN}, 32'h1);
		chk("data enable after reset", {31'h0, sdoOeN}, 32'h1);
		chk("frame idle after reset", {31'h0, frameOut}, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		chk("unmapped data", rdv, 32'h0);
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, spc_pkg::CTRL_OFS, {16'h0, rowCtrl[i]});
			repeat (2) @(posedge clk);
			chk("pin use", {27'h0, sdiOwned, sckOwned, ssOwned, sckOeN, sckOut}, {27'h0, rowExp[i]});
			rdc(spc_pkg::CTRL_OFS, {16'h0, rowCtrl[i]}, "ctrl readback");
		end
		apb(1'b1, spc_pkg::CTRL_OFS, 32'h0);
		apb(1'b1, spc_pkg::CTRL_OFS, 32'h4);
		rdc(spc_pkg::CTRL_OFS, 32'h4, "baud source while off");
		apb(1'b1, spc_pkg::CTRL_OFS, 32'h8000);
		rdc(spc_pkg::CTRL_OFS, 32'h8000, "baud source cleared while off");
		apb(1'b1, spc_pkg::CTRL_OFS, 32'h8004);
		rdc(spc_pkg::CTRL_OFS, 32'h8000, "baud source kept while on");
		apb(1'b1, spc_pkg::BAUD_OFS, 32'h7);
		xfer(16'h8020, 1'b0, 1'b0, 8'ha5, 8'h3c);
		xfer(16'h8120, 1'b1, 1'b0, 8'h96, 8'h5a);
		xfer(16'h8320, 1'b0, 1'b0, 8'hc3, 8'h81);
		xfer(16'h8064, 1'b0, 1'b1, 8'h0f, 8'hf0);
		chk("frame quiet when not framed", {31'h0, frameOut}, 32'h0);
		chk("data enabled while on", {31'h0, sdoOeN}, 32'h0);
		apb(1'b1, spc_pkg::CTRL_OFS, 32'h0);
		apb(1'b1, spc_pkg::DATA_OFS, 32'h11);
		rdc(spc_pkg::STAT_OFS, 32'h2, "standard buffer full");
		apb(1'b1, spc_pkg::DATA_OFS, 32'h22);
		rdc(spc_pkg::STAT_OFS, 32'h12, "standard buffer overflow");
		apb(1'b1, spc_pkg::STAT_OFS, 32'h18);
		apb(1'b1, spc_pkg::CTRL_OFS, 32'h1);
		apb(1'b1, spc_pkg::DATA_OFS, 32'h33);
		rdc(spc_pkg::STAT_OFS, 32'h2, "enhanced buffer second word");
		conclude();
	end
endmodule : tb
